// File: logic/smsp_consts.svh
`ifndef SMSP_CONSTS_SVH
`define SMSP_CONSTS_SVH

// Byte geometry of the serial shift path.
`define SMSP_BYTE_W        8
`define SMSP_CNT_W         3
`define SMSP_LAST_BIT      3'h7
`define SMSP_FIRST_BIT     3'h0
`define SMSP_EDGE_W        4
`define SMSP_LAST_EDGE     4'hF
`define SMSP_FIRST_EDGE    4'h0

// Master clock half periods in core cycles, normal speed (divisors 4, 16, 64, 128).
`define SMSP_TMR_W         7
`define SMSP_HALF_RATE0    7'h02
`define SMSP_HALF_RATE1    7'h08
`define SMSP_HALF_RATE2    7'h20
`define SMSP_HALF_RATE3    7'h40
`define SMSP_TMR_ONE       7'h01
`define SMSP_TMR_ZERO      7'h00

// Receive FIFO shape.
`define SMSP_FIFO_DEPTH    16
`define SMSP_FIFO_AW       4

// Reset values.
`define SMSP_BYTE_ZERO     8'h00
`define SMSP_CNT_ZERO      3'h0

`endif

// File: logic/smsp_pkg.sv
package smsp_pkg;

  // Master sequencer states.
  typedef enum logic
  {
    SMSP_IDLE,
    SMSP_SHIFT
  } smsp_state_e;

  typedef logic [7:0] smsp_byte_t;

endpackage : smsp_pkg

// File: logic/smsp_fifo.sv
`timescale 1ns/10ps
`include "smsp_consts.svh"

module smsp_fifo
  import smsp_pkg::*;
#(
  parameter int WIDTH = `SMSP_BYTE_W,
  parameter int DEPTH = `SMSP_FIFO_DEPTH,
  parameter int AW    = `SMSP_FIFO_AW
)
(
  input  wire logic             core_clk,
  input  wire logic             arst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      fill;

  // The head word sits in an output register, so the array holds DEPTH more behind it.
  wire       push      = in_valid & in_ready;
  wire       load_out  = ~out_valid | out_ready;
  wire       mem_empty = (fill == '0);
  wire       from_mem  = load_out & ~mem_empty;
  wire       bypass    = load_out & mem_empty & push;
  wire       to_mem    = push & ~bypass;
  wire [AW:0] fill_inc = fill + {{AW{1'b0}}, to_mem};
  assign in_ready = (fill != DEPTH[AW:0]);

  // Storage array is left unreset; pointers, fill count and output register carry the reset state.
  always_ff @(posedge core_clk)
  begin
    if (to_mem)
      mem[wr_ptr] <= in_data;
  end

  // Pointer, fill and output register bookkeeping.
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wr_ptr    <= '0;
      rd_ptr    <= '0;
      fill      <= '0;
      out_valid <= 1'b0;
      out_data  <= '0;
    end
    else
    begin
      if (to_mem)
        wr_ptr <= wr_ptr + 1'b1;
      if (from_mem)
      begin
        rd_ptr   <= rd_ptr + 1'b1;
        out_data <= mem[rd_ptr];
      end
      else if (bypass)
        out_data <= in_data;
      fill      <= fill_inc - {{AW{1'b0}}, from_mem};
      out_valid <= from_mem | bypass | (out_valid & ~out_ready);
    end
  end

endmodule : smsp_fifo

// File: logic/smsp_port.sv
// Operation
// - Master write to data register starts clock generator and shifts out eight bits.
// - Master stops clock after one full byte and sets transfer-done flag.
// - Transfer-done flag with interrupt enable raises interrupt in either mode.
// - Master never drives the slave select line itself.
// - MOSI carries master to slave, MISO slave to master, exchanged per clock.
// - Master continues with another data write, or ends packet by raising select.
// - Slave with select high stays idle with MISO not driven.
// - Slave data loaded while select high shifts only after select goes low.
// - Slave sets transfer-done flag once a complete byte is shifted.
// - Slave may load new transmit data before reading the received byte.
// - Single transmit buffer; no new write until current shift cycle finishes.
// - Receive FIFO of 16 bytes plus output register; a byte completing while it is full is not queued and sets overrun.
// - Most recently received byte is kept in a readable register.
// - While enabled, SCK and MOSI drive only as master and MISO only as selected slave, each only when its user drive bit is set.
// - Port works only while its power-off control bit is zero.
// - Slave select going high resets logic and discards a partial byte.
// - Master SCK is clock over 4/16/64/128, halved by double speed.
// - Polarity sets SCK idle level; phase picks leading or trailing sampling.
// - Data order bit one sends LSB first, zero sends MSB first.
`timescale 1ns/10ps
`include "smsp_consts.svh"

module smsp_port
  import smsp_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       arst_n,
  input  wire logic       port_enable_bit,
  input  wire logic       serial_power_off_bit,
  input  wire logic       master_select,
  input  wire logic       lsb_first_select,
  input  wire logic       clock_polarity,
  input  wire logic       clock_phase,
  input  wire logic       rate_select_hi,
  input  wire logic       rate_select_lo,
  input  wire logic       double_speed_bit,
  input  wire logic       transfer_irq_enable,
  input  wire logic       mosi_user_drive,
  input  wire logic       miso_user_drive,
  input  wire logic       sck_user_drive,
  input  wire logic       tx_write,
  input  wire logic [7:0] tx_data,
  output logic            tx_ready,
  input  wire logic       flag_clear,
  output logic            transfer_done_flag,
  output logic            write_collision_flag,
  output logic            rx_overrun_flag,
  output logic            irq,
  output logic            busy,
  output logic [7:0]      serial_data_register,
  output logic            rx_valid,
  input  wire logic       rx_ready,
  output logic [7:0]      rx_data,
  input  wire logic       ss_n_in,
  input  wire logic       sck_in,
  output logic            sck_out,
  output logic            sck_oe_n,
  input  wire logic       mosi_in,
  output logic            mosi_out,
  output logic            mosi_oe_n,
  input  wire logic       miso_in,
  output logic            miso_out,
  output logic            miso_oe_n
);

  // Half period of the master clock in core cycles for the selected rate.
  function automatic logic [`SMSP_TMR_W-1:0] half_period(input logic [1:0] rate,
                                                         input logic dbl);
    logic [`SMSP_TMR_W-1:0] base;
    begin
      base = `SMSP_HALF_RATE0;
      case (rate)
        2'h0:    base = `SMSP_HALF_RATE0;
        2'h1:    base = `SMSP_HALF_RATE1;
        2'h2:    base = `SMSP_HALF_RATE2;
        default: base = `SMSP_HALF_RATE3;
      endcase
      half_period = dbl ? (base >> 1) : base;
    end
  endfunction : half_period

  // Bit that goes onto the data line next, according to the data order.
  function automatic logic out_bit(input logic [7:0] sh, input logic lsb);
    begin
      out_bit = lsb ? sh[0] : sh[7];
    end
  endfunction : out_bit

  // Shift register after one sampled bit enters at the far end.
  function automatic logic [7:0] shift_in(input logic [7:0] sh, input logic b,
                                          input logic lsb);
    begin
      shift_in = lsb ? {b, sh[7:1]} : {sh[6:0], b};
    end
  endfunction : shift_in

  smsp_state_e            state;
  logic [7:0]             shreg;
  logic [`SMSP_CNT_W-1:0] bit_cnt;
  logic [`SMSP_EDGE_W-1:0] edge_idx;
  logic [`SMSP_TMR_W-1:0] timer;
  logic                   sck_q;
  logic                   data_q;
  logic                   ss_s1, ss_s2;
  logic                   sck_s1, sck_s2, sck_s3;
  logic                   mosi_s1, mosi_s2;
  logic                   miso_s1, miso_s2;
  logic                   fifo_ready;

  // Role decode; the port is dead while powered off or disabled.
  wire active       = port_enable_bit & ~serial_power_off_bit;
  wire is_master    = active & master_select;
  wire slave_active = active & ~master_select & ~ss_s2;
  wire slave_idle   = active & ~master_select & ss_s2;
  wire [`SMSP_TMR_W-1:0] half = half_period({rate_select_hi, rate_select_lo},
                                            double_speed_bit);

  // Master timing: the timer expires once per half period of SCK.
  wire m_shift   = (state == SMSP_SHIFT);
  wire m_edge    = m_shift & (timer == `SMSP_TMR_ONE);
  wire m_lead    = (sck_q == clock_polarity);
  wire m_last    = m_edge & (edge_idx == `SMSP_LAST_EDGE);

  // Slave edges are found on the synchronised SCK, never on the first stage.
  wire s_edge    = slave_active & (sck_s2 != sck_s3);
  wire s_lead    = (sck_s3 == clock_polarity);

  // Shared edge classification: sample on leading edges when phase is zero.
  wire edge_evt   = is_master ? m_edge : s_edge;
  wire edge_lead  = is_master ? m_lead : s_lead;
  wire sample_evt = edge_evt & (edge_lead ^ clock_phase);
  wire setup_evt  = edge_evt & ~(edge_lead ^ clock_phase);
  wire in_bit     = is_master ? miso_s2 : mosi_s2;
  wire rx_cap     = sample_evt & (bit_cnt == `SMSP_LAST_BIT);
  wire [7:0] next_shreg = shift_in(shreg, in_bit, lsb_first_select);

  // Completion: the slave at its eighth sample, the master once SCK is back at idle.
  wire done_evt  = is_master ? m_last : (rx_cap & slave_active);
  wire s_abort   = slave_idle & (bit_cnt != `SMSP_CNT_ZERO);

  // One transmit buffer: writes are taken only between bytes.
  assign busy     = m_shift | (slave_active & (bit_cnt != `SMSP_CNT_ZERO));
  assign tx_ready = active & ~busy & (~master_select | fifo_ready);
  wire   tx_take  = tx_write & tx_ready;
  wire   m_start  = tx_take & is_master;
  wire   rx_push  = rx_cap & (is_master | slave_active);

  // Pin input synchronisers; the first stages feed only the second.
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ss_s1   <= 1'b1;
      ss_s2   <= 1'b1;
      sck_s1  <= 1'b0;
      sck_s2  <= 1'b0;
      sck_s3  <= 1'b0;
      mosi_s1 <= 1'b0;
      mosi_s2 <= 1'b0;
      miso_s1 <= 1'b0;
      miso_s2 <= 1'b0;
    end
    else
    begin
      ss_s1   <= ss_n_in;
      ss_s2   <= ss_s1;
      sck_s1  <= sck_in;
      sck_s2  <= sck_s1;
      sck_s3  <= sck_s2;
      mosi_s1 <= mosi_in;
      mosi_s2 <= mosi_s1;
      miso_s1 <= miso_in;
      miso_s2 <= miso_s1;
    end
  end

  // Master sequencer: one start per write, sixteen SCK edges per byte.
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state    <= SMSP_IDLE;
      timer    <= `SMSP_TMR_ZERO;
      edge_idx <= `SMSP_FIRST_EDGE;
      sck_q    <= 1'b0;
    end
    else
    begin
      case (state)
        SMSP_IDLE:
        begin
          sck_q    <= clock_polarity;
          edge_idx <= `SMSP_FIRST_EDGE;
          // One spare cycle lets the first data bit settle before the first edge.
          timer    <= half + `SMSP_TMR_ONE;
          if (m_start)
            state <= SMSP_SHIFT;
        end
        SMSP_SHIFT:
        begin
          if (!is_master)
            state <= SMSP_IDLE;
          else if (m_edge)
          begin
            sck_q    <= ~sck_q;
            timer    <= half;
            edge_idx <= edge_idx + 1'b1;
            if (m_last)
              state <= SMSP_IDLE;
          end
          else
            timer <= timer - `SMSP_TMR_ONE;
        end
        default:
          state <= SMSP_IDLE;
      endcase
    end
  end

  // Shift register and bit counter, shared by both roles.
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      shreg   <= `SMSP_BYTE_ZERO;
      bit_cnt <= `SMSP_CNT_ZERO;
    end
    else if (!active)
      bit_cnt <= `SMSP_CNT_ZERO;
    else if (s_abort)
    begin
      shreg   <= `SMSP_BYTE_ZERO;
      bit_cnt <= `SMSP_CNT_ZERO;
    end
    else if (tx_take)
      shreg <= tx_data;
    else if (sample_evt)
    begin
      shreg   <= next_shreg;
      bit_cnt <= bit_cnt + 1'b1;
    end
  end

  // Output data bit: presented before the first edge when phase is zero, and changed on setup edges.
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      data_q <= 1'b0;
    else if (setup_evt | (~clock_phase & ~edge_evt & (bit_cnt == `SMSP_CNT_ZERO)))
      data_q <= out_bit(shreg, lsb_first_select);
  end

  // Latest received byte stays readable; the FIFO keeps older unread bytes.
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      serial_data_register <= `SMSP_BYTE_ZERO;
    else if (rx_push)
      serial_data_register <= next_shreg;
  end

  // Sticky flags; a set arriving with the clear wins.
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      transfer_done_flag   <= 1'b0;
      write_collision_flag <= 1'b0;
      rx_overrun_flag      <= 1'b0;
    end
    else
    begin
      transfer_done_flag   <= done_evt | (transfer_done_flag & ~flag_clear);
      write_collision_flag <= (tx_write & active & busy) |
                              (write_collision_flag & ~flag_clear);
      rx_overrun_flag      <= (rx_push & ~fifo_ready) |
                              (rx_overrun_flag & ~flag_clear);
    end
  end

  // Interrupt request follows the flag in either role.
  assign irq = transfer_done_flag & transfer_irq_enable;

  // Pin drive: enables are active low; select is never driven here.
  assign sck_out   = sck_q;
  assign mosi_out  = data_q;
  assign miso_out  = data_q;
  assign sck_oe_n  = ~(is_master & sck_user_drive);
  assign mosi_oe_n = ~(is_master & mosi_user_drive);
  assign miso_oe_n = ~(slave_active & miso_user_drive);

  // Received bytes queue here; a full queue holds the master off its next byte.
  smsp_fifo #(
    .WIDTH (`SMSP_BYTE_W),
    .DEPTH (`SMSP_FIFO_DEPTH),
    .AW    (`SMSP_FIFO_AW)
  ) u_rx_fifo (
    .core_clk  (core_clk),
    .arst_n    (arst_n),
    .in_valid  (rx_push),
    .in_ready  (fifo_ready),
    .in_data   (next_shreg),
    .out_valid (rx_valid),
    .out_ready (rx_ready),
    .out_data  (rx_data)
  );

  // Checks on the behaviour above.
  sequence s_start_seen;
    m_start ##1 (state == SMSP_SHIFT);
  endsequence

  chk_start_runs_clock: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    m_start |=> (state == SMSP_SHIFT))
    else $error("Master write did not start the sequencer.");

  chk_start_clock_idle: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    s_start_seen |-> (sck_q == $past(clock_polarity)))
    else $error("SCK left idle level before the first half period.");

  chk_master_stops: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    m_last |=> (state == SMSP_IDLE) && transfer_done_flag)
    else $error("Master did not stop and flag after the last edge.");

  chk_irq_follows_flag: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    irq == (transfer_done_flag && transfer_irq_enable))
    else $error("Interrupt request disagrees with flag and enable.");

  chk_slave_quiet_high: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    slave_idle |-> miso_oe_n)
    else $error("MISO driven while slave is deselected.");

  chk_slave_done_flag: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    (rx_cap && slave_active) |=> transfer_done_flag)
    else $error("Slave byte completed without setting the flag.");

  chk_tx_busy_refused: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    (tx_write && busy && active) |=> write_collision_flag && ($stable(shreg) || $past(sample_evt)))
    else $error("Write during a shift was not refused.");

  chk_abort_discards: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    s_abort |=> (bit_cnt == `SMSP_CNT_ZERO) && (shreg == `SMSP_BYTE_ZERO))
    else $error("Deselect did not discard the partial byte.");

  chk_power_off_idle: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    !active |-> !tx_ready && sck_oe_n && mosi_oe_n && miso_oe_n)
    else $error("Port acted while powered off or disabled.");

  chk_last_byte_kept: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    rx_push |=> (serial_data_register == $past(next_shreg)))
    else $error("Received byte not kept in the data register.");

  chk_overrun_marked: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    (rx_push && !fifo_ready) |=> rx_overrun_flag)
    else $error("Lost receive byte not marked as overrun.");

endmodule : smsp_port

// File: sim/smsp_far_end.sv
`timescale 1ns/10ps

// Far end of the link: a slave while the port is master, a master while the port is slave.
module smsp_far_end
#(
  parameter int HALF = 8
)
(
  input  wire logic core_clk,
  input  wire logic cpol,
  input  wire logic cpha,
  input  wire logic lsb,
  input  wire logic sck_pin,
  input  wire logic mosi_pin,
  input  wire logic miso_pin,
  output logic      sel_n,
  output logic      sck_m,
  output logic      mosi_m,
  output logic      miso_s
);
  logic [7:0] tx_byte;
  logic [7:0] rx_byte;
  logic [2:0] idx;
  logic       as_master;

  function automatic logic pick(input logic [7:0] b, input int i);
    return lsb ? b[i] : b[7-i];
  endfunction : pick

  function automatic logic [7:0] shin(input logic [7:0] r, input logic b);
    return lsb ? {b, r[7:1]} : {r[6:0], b};
  endfunction : shin

  // A deselected slave shows the inverse bit, so a stale level never passes for data.
  assign miso_s = sel_n ? ~pick(tx_byte, int'(idx)) : pick(tx_byte, int'(idx));

  initial
  begin
    sel_n     = 1'b1;
    sck_m     = 1'b0;
    mosi_m    = 1'b0;
    as_master = 1'b0;
    tx_byte   = 8'h00;
    rx_byte   = 8'h00;
    idx       = 3'h0;
  end

  // Slave role: sample on one kind of edge, step to the next bit on the other.
  always @(sck_pin)
    if (!sel_n && !as_master)
    begin
      if ((sck_pin !== cpol) ^ cpha)
        rx_byte = shin(rx_byte, mosi_pin);
      else
        idx = idx + 3'h1;
    end

  // Selecting starts a packet with a fresh bit index.
  task automatic select(input logic [7:0] tx);
    tx_byte = tx;
    idx     = cpha ? 3'h7 : 3'h0;
    sck_m   = cpol;
    sel_n   = 1'b0;
  endtask : select

  // Raising select after a packet keeps the slave's bit count in step.
  task automatic deselect();
    sel_n = 1'b1;
  endtask : deselect

  // Master role: every clock phase lasts HALF core cycles, well over two.
  task automatic xfer(input logic [7:0] tx, input int nbits);
    as_master = 1'b1;
    for (int i = 0; i < nbits; i++)
    begin
      mosi_m = cpha ? mosi_m : pick(tx, i);
      repeat (HALF) @(negedge core_clk);
      sck_m   = ~cpol;
      mosi_m  = cpha ? pick(tx, i) : mosi_m;
      rx_byte = cpha ? rx_byte : shin(rx_byte, miso_pin);
      repeat (HALF) @(negedge core_clk);
      sck_m   = cpol;
      rx_byte = cpha ? shin(rx_byte, miso_pin) : rx_byte;
    end
    repeat (HALF) @(negedge core_clk);
    mosi_m    = ~mosi_m;
    as_master = 1'b0;
  endtask : xfer
endmodule : smsp_far_end

// File: sim/test_smsp_port.sv
`timescale 1ns/10ps

module test_smsp_port
  import smsp_pkg::*;
;
  logic       core_clk, arst_n, port_enable_bit, serial_power_off_bit, master_select;
  logic       lsb_first_select, clock_polarity, clock_phase, rate_select_hi, rate_select_lo;
  logic       double_speed_bit, transfer_irq_enable, mosi_user_drive, miso_user_drive;
  logic       sck_user_drive, tx_write, tx_ready, flag_clear, transfer_done_flag;
  logic       write_collision_flag, rx_overrun_flag, irq, busy, rx_valid, rx_ready;
  logic       ss_n_in, sck_in, sck_out, sck_oe_n, mosi_in, mosi_out, mosi_oe_n;
  logic       miso_in, miso_out, miso_oe_n, sel_n, sck_m, mosi_m, miso_s, sck_prev;
  smsp_byte_t tx_data, serial_data_register, rx_data, d;
  int         n_fail, tests_run, half_cnt, half_seen;
  int         halves[8] = '{2, 8, 32, 64, 1, 4, 16, 32};

  smsp_port i_smsp_port
  (
    .core_clk, .arst_n, .port_enable_bit, .serial_power_off_bit, .master_select,
    .lsb_first_select, .clock_polarity, .clock_phase, .rate_select_hi, .rate_select_lo,
    .double_speed_bit, .transfer_irq_enable, .mosi_user_drive, .miso_user_drive,
    .sck_user_drive, .tx_write, .tx_data, .tx_ready, .flag_clear, .transfer_done_flag,
    .write_collision_flag, .rx_overrun_flag, .irq, .busy, .serial_data_register, .rx_valid,
    .rx_ready, .rx_data, .ss_n_in, .sck_in, .sck_out, .sck_oe_n, .mosi_in, .mosi_out,
    .mosi_oe_n, .miso_in, .miso_out, .miso_oe_n
  );

  smsp_far_end #(.HALF(8)) i_smsp_far_end
  (
    .core_clk, .cpol(clock_polarity), .cpha(clock_phase), .lsb(lsb_first_select),
    .sck_pin(sck_in), .mosi_pin(mosi_in), .miso_pin(miso_in), .sel_n, .sck_m, .mosi_m, .miso_s
  );

  // Each pin carries whichever side has its driver enabled.
  assign ss_n_in = sel_n;
  assign sck_in  = !sck_oe_n ? sck_out : sck_m;
  assign mosi_in = !mosi_oe_n ? mosi_out : mosi_m;
  assign miso_in = !miso_oe_n ? miso_out : miso_s;

  always #2 core_clk = ~core_clk;

  // Cycles between clock toggles give the running half period.
  always @(posedge core_clk)
  begin
    half_cnt  <= (sck_out !== sck_prev) ? 1 : half_cnt + 1;
    half_seen <= (sck_out !== sck_prev) ? half_cnt : half_seen;
    sck_prev  <= sck_out;
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    tests_run++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t ns: %s is %h, expected %h", $time, what, got, exp);
    end
  endtask : check

  task automatic end_sim();
    $display("comparisons %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim

  // Bounded wait for completion (0) or receive data (1); running out ends the run.
  task automatic wait_high(input int which, input int limit);
    int n;
    n = 0;
    while ((which == 0 ? transfer_done_flag : rx_valid) !== 1'b1)
    begin
      @(negedge core_clk);
      n++;
      if (n > limit)
      begin
        n_fail++;
        $display("wrong value at %0t ns: wait ran out", $time);
        end_sim();
      end
    end
  endtask : wait_high

  task automatic write_tx(input smsp_byte_t v);
    tx_data  = v;
    tx_write = 1'b1;
    @(negedge core_clk);
    tx_write = 1'b0;
  endtask : write_tx

  task automatic clear_flags();
    flag_clear = 1'b1;
    @(negedge core_clk);
    flag_clear = 1'b0;
  endtask : clear_flags

  // Popping follows the data handshake, so an empty buffer is never read.
  task automatic pop(input smsp_byte_t exp);
    wait_high(1, 60);
    check(rx_data, exp, "buffered byte");
    rx_ready = 1'b1;
    @(negedge core_clk);
    rx_ready = 1'b0;
    // One idle edge keeps ready from being lowered and raised in one time step.
    @(negedge core_clk);
  endtask : pop

  task automatic drain();
    for (int i = 0; i < 40; i++)
    begin
      rx_ready = rx_valid;
      @(negedge core_clk);
    end
    rx_ready = 1'b0;
  endtask : drain

  // Main sequence: reset, power-off, master modes, collision, slave, receive buffer.
  initial
  begin
    core_clk = 1'b0;
    arst_n   = 1'b0;
    {port_enable_bit, serial_power_off_bit, master_select, lsb_first_select} = 4'h0;
    {clock_polarity, clock_phase, rate_select_hi, rate_select_lo} = 4'h0;
    {double_speed_bit, transfer_irq_enable, tx_write, flag_clear, rx_ready} = 5'h00;
    {mosi_user_drive, miso_user_drive, sck_user_drive} = 3'h7;
    tx_data   = 8'h00;
    n_fail    = 0;
    tests_run = 0;
    repeat (20) @(negedge core_clk);
    check(8'({transfer_done_flag, rx_overrun_flag, rx_valid}), 8'h00, "reset flags");
    check(8'({sck_oe_n, mosi_oe_n, miso_oe_n}), 8'h07, "reset pins");
    arst_n = 1'b1;
    repeat (3) @(negedge core_clk);
    {port_enable_bit, serial_power_off_bit, master_select} = 3'h7;
    i_smsp_far_end.select(8'h00);
    write_tx(8'h5A);
    repeat (40) @(negedge core_clk);
    check(8'({busy, transfer_done_flag, write_collision_flag}), 8'h00, "off");
    i_smsp_far_end.deselect();
    serial_power_off_bit = 1'b0;
    $display("test power off finished");
    for (int k = 0; k < 8; k++)
    begin
      {double_speed_bit, rate_select_hi, rate_select_lo} = 3'(k);
      {lsb_first_select, clock_phase, clock_polarity} = 3'(k);
      transfer_irq_enable = k[0];
      d = 8'(8'h96 + k * 37);
      repeat (4) @(negedge core_clk);
      i_smsp_far_end.select(~d);
      write_tx(d);
      wait_high(0, 3000);
      check(i_smsp_far_end.rx_byte, d, "mosi byte");
      check(8'(half_seen), 8'(halves[k]), "half period");
      check(8'({busy, sck_out}), 8'(clock_polarity), "clock stopped");
      check(8'(irq), 8'(k[0]), "irq");
      check(8'({miso_oe_n, mosi_oe_n, sck_oe_n}), 8'h04, "master pins");
      if (halves[k] >= 4)
        check(serial_data_register, ~d, "miso byte");
      clear_flags();
      i_smsp_far_end.deselect();
    end
    $display("test master modes finished");
    {double_speed_bit, rate_select_hi, rate_select_lo} = 3'h5;
    {lsb_first_select, clock_phase, clock_polarity} = 3'h0;
    repeat (4) @(negedge core_clk);
    i_smsp_far_end.select(8'h5A);
    write_tx(8'hC3);
    repeat (10) @(negedge core_clk);
    check(8'({busy, tx_ready}), 8'h02, "busy refuses");
    write_tx(8'h11);
    @(negedge core_clk);
    check(8'(write_collision_flag), 8'h01, "collision");
    wait_high(0, 500);
    check(i_smsp_far_end.rx_byte, 8'hC3, "first byte kept");
    flag_clear = 1'b1;
    write_tx(8'h7E);
    flag_clear = 1'b0;
    wait_high(0, 500);
    check(i_smsp_far_end.rx_byte, 8'h7E, "back to back");
    check(serial_data_register, 8'h5A, "second reply");
    clear_flags();
    i_smsp_far_end.deselect();
    $display("test collision finished");
    {mosi_user_drive, sck_user_drive} = 2'h0;
    @(negedge core_clk);
    check(8'({mosi_oe_n, sck_oe_n}), 8'h03, "master user inputs");
    master_select   = 1'b0;
    miso_user_drive = 1'b0;
    {clock_phase, clock_polarity} = 2'h3;
    repeat (4) @(negedge core_clk);
    write_tx(8'hB4);
    i_smsp_far_end.xfer(8'h0F, 8);
    check(8'({transfer_done_flag, miso_oe_n}), 8'h01, "deselected");
    i_smsp_far_end.select(8'h00);
    repeat (6) @(negedge core_clk);
    check(8'(miso_oe_n), 8'h01, "miso as input");
    miso_user_drive = 1'b1;
    @(negedge core_clk);
    check(8'(miso_oe_n), 8'h00, "miso as output");
    i_smsp_far_end.xfer(8'h69, 8);
    wait_high(0, 100);
    check(i_smsp_far_end.rx_byte, 8'hB4, "slave reply");
    check(serial_data_register, 8'h69, "slave byte");
    check(8'(irq), 8'h01, "slave irq");
    write_tx(8'hD2);
    clear_flags();
    i_smsp_far_end.xfer(8'h33, 8);
    wait_high(0, 100);
    check(i_smsp_far_end.rx_byte, 8'hD2, "reload");
    check(serial_data_register, 8'h33, "second byte");
    clear_flags();
    i_smsp_far_end.xfer(8'hFF, 7);
    check(8'(transfer_done_flag), 8'h00, "seven bits");
    i_smsp_far_end.deselect();
    repeat (6) @(negedge core_clk);
    i_smsp_far_end.select(8'h00);
    i_smsp_far_end.xfer(8'h5C, 8);
    wait_high(0, 100);
    check(serial_data_register, 8'h5C, "after abort");
    $display("test slave finished");
    drain();
    clear_flags();
    for (int j = 0; j < 18; j++)
    begin
      i_smsp_far_end.xfer(8'(8'h40 + j), 8);
      wait_high(0, 100);
      repeat (2) @(negedge core_clk);
      check(8'(rx_overrun_flag), 8'(j == 17), "overrun");
      clear_flags();
    end
    check(serial_data_register, 8'h51, "newest byte");
    for (int j = 0; j < 17; j++)
      pop(8'(8'h40 + j));
    repeat (3) @(negedge core_clk);
    check(8'(rx_valid), 8'h00, "drained");
    $display("test receive buffer finished");
    end_sim();
  end
endmodule : test_smsp_port
